/* rtl/gpio_upper_defs.vh */
// register map, field layout and reset values of the upper gpio bank
`ifndef GPIO_UPPER_DEFS_VH
`define GPIO_UPPER_DEFS_VH

// bus widths
`define GPIO_ADDR_W 16
`define GPIO_DATA_W 16

// pin counts
`define GPIO_LO_PINS 16
`define GPIO_TOP_PINS 14
`define GPIO_ALL_PINS 30

// first pin number of each group
`define GPIO_LO_FIRST_PIN 16
`define GPIO_TOP_FIRST_PIN 32

// register offsets (word addresses on the register port)
`define GPIO_OFS_EN_HI16 16'h4403
`define GPIO_OFS_DIR_HI16 16'h4404
`define GPIO_OFS_LVL_HI16 16'h4405
`define GPIO_OFS_EN_TOP14 16'h4406
`define GPIO_OFS_DIR_TOP14 16'h4407
`define GPIO_OFS_LVL_TOP14 16'h4408

// field positions in the 14-pin registers
`define GPIO_TOP_PIN_MSB 13
`define GPIO_TOP_RSV_MSB 15
`define GPIO_TOP_RSV_LSB 14

// reset values
`define GPIO_RST_EN 16'h0000
`define GPIO_RST_DIR 16'h0000
`define GPIO_RST_RSV 2'h0
`define GPIO_RST_RDATA 16'h0000
`define GPIO_RST_PINS 30'h00000000
`define GPIO_RST_EN14 14'h0000
`define GPIO_RST_DIR14 14'h0000
`define GPIO_RST_LVL16 16'h0000
`define GPIO_RST_LVL14 14'h0000

// synchroniser depth
`define GPIO_SYNC_STAGES 2

`endif

/* rtl/parallel_gpio_bank_upper.v */
// register file and pin control of the gpio bank for pins 16 to 45
//
// Contract
// - direction 0 means input; resets to 0
// - direction 1 drives pin from data bit
// - input pin reads 0 low, 1 high
// - output pin drives written data level
// - enable 0 puts pin in high impedance
// - enable 1 gives gpio under direction, data
// - data bit holds pin level after reset
// - bit n maps to pin 16 plus n, in the top14 registers to pin 32 plus n
// - top enable bits 13-0, reserved 15-14
// - enable for pins 16-31 at 0x4403
// - direction for pins 32-45 at 0x4407
`timescale 1ns/1ps
`include "gpio_upper_defs.vh"

module parallel_gpio_bank_upper (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register port
  input wire [`GPIO_ADDR_W-1:0] addr,
  input wire [`GPIO_DATA_W-1:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [`GPIO_DATA_W-1:0] rd_data,
  // pins 16 to 45, bit 0 is pin 16
  input wire [`GPIO_ALL_PINS-1:0] pin_in,
  output wire [`GPIO_ALL_PINS-1:0] pin_out,
  output wire [`GPIO_ALL_PINS-1:0] pin_oe_n
);

  // software-visible state
  reg [`GPIO_LO_PINS-1:0] pin_function_enable_hi16;
  reg [`GPIO_LO_PINS-1:0] pin_direction_hi16;
  reg [`GPIO_LO_PINS-1:0] pin_level_hi16;
  reg [`GPIO_TOP_PINS-1:0] pin_function_enable_top14;
  reg [`GPIO_TOP_PINS-1:0] pin_direction_top14;
  reg [`GPIO_TOP_PINS-1:0] pin_level_top14;
  reg [1:0] en_top14_rsv;
  reg [1:0] dir_top14_rsv;
  reg [1:0] lvl_top14_rsv;

  // next values
  reg [`GPIO_LO_PINS-1:0] next_level_hi16;
  reg [`GPIO_TOP_PINS-1:0] next_level_top14;
  reg [`GPIO_DATA_W-1:0] next_rd_data;

  // synchronised pin levels
  wire [`GPIO_ALL_PINS-1:0] pin_sync;
  wire [`GPIO_LO_PINS-1:0] sync_hi16;
  wire [`GPIO_TOP_PINS-1:0] sync_top14;

  // address decode
  wire hit_en_hi16;
  wire hit_dir_hi16;
  wire hit_lvl_hi16;
  wire hit_en_top14;
  wire hit_dir_top14;
  wire hit_lvl_top14;

  assign hit_en_hi16 = (addr == `GPIO_OFS_EN_HI16);
  assign hit_dir_hi16 = (addr == `GPIO_OFS_DIR_HI16);
  assign hit_lvl_hi16 = (addr == `GPIO_OFS_LVL_HI16);
  assign hit_en_top14 = (addr == `GPIO_OFS_EN_TOP14);
  assign hit_dir_top14 = (addr == `GPIO_OFS_DIR_TOP14);
  assign hit_lvl_top14 = (addr == `GPIO_OFS_LVL_TOP14);

  // bit n of a hi16 register is pin 16 plus n, of a top14 register pin 32 plus n; pin 32 is bit 16 of the vectors
  assign sync_hi16 = pin_sync[`GPIO_LO_PINS-1:0];
  assign sync_top14 = pin_sync[`GPIO_ALL_PINS-1:`GPIO_LO_PINS];

  pin_sync2 u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // control registers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_function_enable_hi16 <= `GPIO_RST_EN;
      pin_direction_hi16 <= `GPIO_RST_DIR;
      pin_function_enable_top14 <= `GPIO_RST_EN14;
      pin_direction_top14 <= `GPIO_RST_DIR14;
      en_top14_rsv <= `GPIO_RST_RSV;
      dir_top14_rsv <= `GPIO_RST_RSV;
      lvl_top14_rsv <= `GPIO_RST_RSV;
    end else if (wr_en) begin
      if (hit_en_hi16) begin
        pin_function_enable_hi16 <= wr_data;
      end
      if (hit_dir_hi16) begin
        pin_direction_hi16 <= wr_data;
      end
      if (hit_en_top14) begin
        pin_function_enable_top14 <= wr_data[`GPIO_TOP_PIN_MSB:0];
        en_top14_rsv <= wr_data[`GPIO_TOP_RSV_MSB:`GPIO_TOP_RSV_LSB];
      end
      if (hit_dir_top14) begin
        pin_direction_top14 <= wr_data[`GPIO_TOP_PIN_MSB:0];
        dir_top14_rsv <= wr_data[`GPIO_TOP_RSV_MSB:`GPIO_TOP_RSV_LSB];
      end
      if (hit_lvl_top14) begin
        lvl_top14_rsv <= wr_data[`GPIO_TOP_RSV_MSB:`GPIO_TOP_RSV_LSB];
      end
    end
  end

  // data bits follow the pin while it is an input, so after reset they show
  // the pin level, and an input turned output starts at the level last seen;
  // a write to an input bit is therefore not kept
  always @* begin
    next_level_hi16 = (pin_direction_hi16 & pin_level_hi16) |
      (~pin_direction_hi16 & sync_hi16);
    if (wr_en && hit_lvl_hi16) begin
      next_level_hi16 = (pin_direction_hi16 & wr_data) |
        (~pin_direction_hi16 & sync_hi16);
    end
    next_level_top14 = (pin_direction_top14 & pin_level_top14) |
      (~pin_direction_top14 & sync_top14);
    if (wr_en && hit_lvl_top14) begin
      next_level_top14 = (pin_direction_top14 & wr_data[`GPIO_TOP_PIN_MSB:0]) |
        (~pin_direction_top14 & sync_top14);
    end
  end

  // the flops reset to a constant; the real pin level arrives three edges on
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_level_hi16 <= `GPIO_RST_LVL16;
      pin_level_top14 <= `GPIO_RST_LVL14;
    end else begin
      pin_level_hi16 <= next_level_hi16;
      pin_level_top14 <= next_level_top14;
    end
  end

  // read path, data stands for one cycle after the strobe
  always @* begin
    next_rd_data = `GPIO_RST_RDATA;
    if (rd_en) begin
      if (hit_en_hi16) begin
        next_rd_data = pin_function_enable_hi16;
      end else if (hit_dir_hi16) begin
        next_rd_data = pin_direction_hi16;
      end else if (hit_lvl_hi16) begin
        next_rd_data = pin_level_hi16;
      end else if (hit_en_top14) begin
        next_rd_data = {en_top14_rsv, pin_function_enable_top14};
      end else if (hit_dir_top14) begin
        next_rd_data = {dir_top14_rsv, pin_direction_top14};
      end else if (hit_lvl_top14) begin
        next_rd_data = {lvl_top14_rsv, pin_level_top14};
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= `GPIO_RST_RDATA;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // pin drivers, one register stage after the control bits
  pin_drive_slice u_drive (
    .sys_clk(sys_clk),
    .rst(rst),
    .func_en({pin_function_enable_top14, pin_function_enable_hi16}),
    .dir_out({pin_direction_top14, pin_direction_hi16}),
    .level({pin_level_top14, pin_level_hi16}),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );

endmodule // parallel_gpio_bank_upper

/* rtl/pin_drive_slice.v */
// per-pin output driver and output enable for the upper gpio bank
`timescale 1ns/1ps
`include "gpio_upper_defs.vh"

module pin_drive_slice (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // per-pin control
  input wire [`GPIO_ALL_PINS-1:0] func_en,
  input wire [`GPIO_ALL_PINS-1:0] dir_out,
  input wire [`GPIO_ALL_PINS-1:0] level,
  // pin side, enable low while driving
  output reg [`GPIO_ALL_PINS-1:0] pin_out,
  output reg [`GPIO_ALL_PINS-1:0] pin_oe_n
);

  genvar i;
  generate
    for (i = 0; i < `GPIO_ALL_PINS; i = i + 1) begin : g_pin
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pin_out[i] <= 1'b0;
          pin_oe_n[i] <= 1'b1;
        end else begin
          // driven only when the function is on and the pin is an output
          pin_oe_n[i] <= ~(func_en[i] & dir_out[i]);
          // data is driven low for 0 and high for 1
          pin_out[i] <= level[i];
        end
      end
    end
  endgenerate

endmodule // pin_drive_slice

/* rtl/pin_sync2.v */
// two flip-flop synchroniser for the input pin levels
`timescale 1ns/1ps
`include "gpio_upper_defs.vh"

module pin_sync2 (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // asynchronous pin levels
  input wire [`GPIO_ALL_PINS-1:0] async_in,
  // levels in the sys_clk domain
  output reg [`GPIO_ALL_PINS-1:0] sync_out
);

  // first stage feeds only the second stage
  reg [`GPIO_ALL_PINS-1:0] meta;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta <= `GPIO_RST_PINS;
      sync_out <= `GPIO_RST_PINS;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pin_sync2

/* sim/board_pins.sv */
// board side of the pins: drives its own levels where the bank lets go
`timescale 1ns/1ps
module board_pins (
  // board levels and bank drive
  input wire [29:0] ext,
  input wire [29:0] pin_out,
  input wire [29:0] pin_oe_n,
  // level seen by the bank
  output wire [29:0] pin_in
);
  // a driven pin shows the bank's level and ignores ext, so a contention cannot show up as a wrong read
  assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule // board_pins

/* sim/gpio_upper_props.sv */
// assertions on the ports of the upper gpio bank
`timescale 1ns/1ps
module gpio_upper_chk (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register port
  input wire [15:0] addr,
  input wire [15:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rd_data,
  // pins
  input wire [29:0] pin_in,
  input wire [29:0] pin_out,
  input wire [29:0] pin_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RST_IDLE: assert property ($fell(rst) |-> &pin_oe_n && rd_data == 16'h0000)
    else $error("outputs not idle after reset");
  AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (rd_en && (addr < 16'h4403 || addr > 16'h4408)
    |=> rd_data == 16'h0000) else $error("unmapped read not zero");
  AST_EN16_OE: assert property (wr_en && addr == 16'h4403
    |=> ##1 &(pin_oe_n[15:0] | $past(wr_data, 2))) else $error("disabled pin driven");
  AST_EN14_OE: assert property (wr_en && addr == 16'h4406
    |=> ##1 &({2'h3, pin_oe_n[29:16]} | $past(wr_data, 2))) else $error("disabled pin driven");
  AST_RB_DIR16: assert property (wr_en && addr == 16'h4404 ##1 rd_en && addr == 16'h4404
    |=> rd_data == $past(wr_data, 2)) else $error("direction readback");
  AST_RB_EN14: assert property (wr_en && addr == 16'h4406 ##1 rd_en && addr == 16'h4406
    |=> rd_data == $past(wr_data, 2)) else $error("enable readback");
  AST_RB_DIR14: assert property (wr_en && addr == 16'h4407 ##1 rd_en && addr == 16'h4407
    |=> rd_data == $past(wr_data, 2)) else $error("top direction readback");
endmodule // gpio_upper_chk
bind parallel_gpio_bank_upper gpio_upper_chk u_chk (.sys_clk(sys_clk), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

/* sim/testbench.sv */
// self-checking bench of the upper gpio bank
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0;
  logic rst = 1;
  logic [15:0] addr = 0;
  logic [15:0] wr_data = 0;
  logic wr_en = 0;
  logic rd_en = 0;
  logic [29:0] ext = 0;
  wire [15:0] rd_data;
  wire [29:0] pin_in, pin_out, pin_oe_n;
  int bad_count = 0;
  int samples_checked = 0;
  logic [15:0] r [6];
  logic [29:0] en, dir, dat;
  always #10 sys_clk = ~sys_clk;
  parallel_gpio_bank_upper u_parallel_gpio_bank_upper (.sys_clk(sys_clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  board_pins u_board_pins (.ext(ext), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
  task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // strobes stay up across back-to-back ops, so no signal is assigned twice at one edge
  task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    op(0, a, 16'h0000);
    rd_en <= 0;
    #1 chk(rd_data, e);
  endtask
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
  initial begin
    void'($urandom(69));
    for (int k = 0; k < 2; k++) begin
      rst <= 1;
      ext <= 30'($urandom);
      repeat (10) @(posedge sys_clk);
      rst <= 0;
      repeat (4) @(posedge sys_clk);
      #1 chk(pin_oe_n, '1);
      foreach (r[i]) rd(16'h4403 + i, i == 2 ? ext[15:0] : i == 5 ? {2'h0, ext[29:16]} : 0);
      rd(16'h4402, 16'h0000);
      rd(16'h4409, 16'h0000);
      for (int n = 0; n < 20; n++) begin
        foreach (r[i]) r[i] = (n < 2) ? {16{n == 0}} : 16'($urandom);
        ext <= 30'($urandom);
        foreach (r[i]) op(1, 16'h4403 + i, r[i]);
        wr_en <= 0;
        // data bits of input pins need two sync flops plus the data flop
        repeat (4) @(posedge sys_clk);
        en = {r[3][13:0], r[0]};
        dir = {r[4][13:0], r[1]};
        dat = (dir & {r[5][13:0], r[2]}) | (~dir & ext);
        #1 chk(pin_oe_n, ~(en & dir));
        chk(pin_out & en & dir, dat & en & dir);
        foreach (r[i]) rd(16'h4403 + i, i == 2 ? dat[15:0] : i == 5 ? {r[5][15:14], dat[29:16]} : r[i]);
        for (int i = 1; i < 5; i++) begin
          if (i != 2) begin
            op(1, 16'h4403 + i, ~r[i]);
            rd(16'h4403 + i, ~r[i]);
          end
        end
      end
    end
    end_sim;
  end
endmodule // testbench
